// >>> verilog/ppl_regs.svh
// Register offsets, field positions, reset values and timing counts of the pin program loader
`ifndef PPL_REGS_SVH
`define PPL_REGS_SVH
`define PPL_ADDR_APLL_CAL 16'h0405
`define PPL_ADDR_SOFT_EN1 16'h0C00
`define PPL_ADDR_SOFT_FREQ 16'h0C01
`define PPL_ADDR_SOFT_SYSCLK 16'h0C02
`define PPL_ADDR_SOFT_EN2 16'h0C03
`define PPL_ADDR_SOFT_LOOP 16'h0C06
`define PPL_ADDR_LOAD_CTRL 16'h0C08
`define PPL_ADDR_LOAD_STAT 16'h0C09
`define PPL_FLD_IN_LSB 0
`define PPL_FLD_OUT_LSB 4
`define PPL_FLD_BW_LSB 2
`define PPL_FLD_PM_BIT 4
`define PPL_FLD_CAL_BIT 0
`define PPL_FLD_EN_BIT 0
`define PPL_FLD_START_BIT 0
`define PPL_RST_BYTE 8'h00
`define PPL_ROM_WORDS 8
`define PPL_SYSCLK_KHZ 786432
`endif

// >>> verilog/ppl_pkg.sv
// Types shared by the pin program loader
package ppl_pkg;
	typedef enum logic [1:0] {
		PPL_TRI_LOW,
		PPL_TRI_MID,
		PPL_TRI_HIGH
	} ppl_tri_type;
	typedef enum {
		PPL_IDLE,
		PPL_COPY,
		PPL_CAL_LOW,
		PPL_CAL_HIGH
	} ppl_state_type;
endpackage : ppl_pkg

// >>> verilog/ppl_loader.sv
// Pin program loader: picks a predefined setup and copies it into the configuration registers
// What this block does
// RULE_01 - Select configuration by strap pins or registers
// RULE_02 - Copy chosen ROM entry into configuration registers
// RULE_03 - 256 entries indexed by input and output
// RULE_04 - One common input and output frequency
// RULE_05 - Load overwrites all listed divider settings
// RULE_06 - Entries assume 786.432 MHz system clock
// RULE_07 - Four system clock PLL presets
// RULE_08 - Four DPLL loop bandwidth presets
// RULE_09 - Normal or high phase margin preset
// RULE_10 - Calibration bit rises, starts VCO calibration
// RULE_11 - Tri-level pins form base-3 index
// RULE_12 - Soft mode picks input by register field
// RULE_13 - Sixteen input frequencies, 8 kHz first
// RULE_14 - Board sets strap mode pin level
// RULE_15 - Software enables sections before select registers
// RULE_16 - Hard mode sysclk from sampled interrupt pin
// RULE_17 - Busy during copy blocks port writes
// RULE_18 - Soft input code decoded by lookup
`timescale 1ns/1ps
`include "ppl_regs.svh"
module ppl_loader #(
	parameter int ROM_WORDS = `PPL_ROM_WORDS
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Strap pins, taken at startup
	input wire logic i_strap_mode_select_pin,
	input wire ppl_pkg::ppl_tri_type i_input_select_pin_high,
	input wire ppl_pkg::ppl_tri_type i_input_select_pin_mid,
	input wire ppl_pkg::ppl_tri_type i_input_select_pin_low,
	input wire ppl_pkg::ppl_tri_type i_out_sel_pin_high,
	input wire ppl_pkg::ppl_tri_type i_out_sel_pin_mid,
	input wire ppl_pkg::ppl_tri_type i_out_sel_pin_low,
	input wire ppl_pkg::ppl_tri_type i_irq_pin,
	// Serial port register access
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// Loaded configuration
	output logic [19:0] o_ref_period,
	output logic [19:0] o_ref_divider,
	output logic [22:0] o_dpll_feedback_fraction,
	output logic [22:0] o_dpll_feedback_modulus,
	output logic [16:0] o_dpll_feedback_integer,
	output logic [31:0] o_free_run_word,
	output logic [7:0] o_output_pll_feedback_divider,
	output logic [3:0] o_rf_divider,
	output logic [9:0] o_channel_divider,
	output logic [1:0] o_sysclk_preset,
	output logic [1:0] o_loop_bw_preset,
	output logic o_high_phase_margin,
	output logic o_apll_cal_start,
	output logic o_busy,
	output logic o_hard_mode,
	output logic o_two_wire_disable
);
	import ppl_pkg::*;

	// The word counter is four bits wide, so longer images cannot be walked
	if (ROM_WORDS < 1 || ROM_WORDS > 15) begin : g_bad_rom_words
		$error("ROM_WORDS out of range");
	end

	// Input code table: printed codes are irregular, decode explicitly
	function automatic logic [3:0] soft_in_decode(input logic [3:0] code);
		case (code) // see RULE_18
			4'h0: soft_in_decode = 4'h0;
			4'h1: soft_in_decode = 4'h1;
			4'h2: soft_in_decode = 4'h2;
			4'h3: soft_in_decode = 4'h3;
			4'h4: soft_in_decode = 4'h4;
			4'h5: soft_in_decode = 4'h5;
			4'h6: soft_in_decode = 4'h6;
			4'h9: soft_in_decode = 4'h8;
			4'h8: soft_in_decode = 4'h9;
			4'hB: soft_in_decode = 4'hA;
			4'hA: soft_in_decode = 4'hB;
			4'hD: soft_in_decode = 4'hC;
			4'hC: soft_in_decode = 4'hD;
			4'hF: soft_in_decode = 4'hE;
			4'hE: soft_in_decode = 4'hF;
			default: soft_in_decode = 4'h7;
		endcase
	endfunction : soft_in_decode

	function automatic logic [3:0] tri_index(input ppl_tri_type h, input ppl_tri_type m,
			input ppl_tri_type l);
		logic [5:0] sum;
		sum = 6'(h) * 6'h09 + 6'(m) * 6'h03 + 6'(l); // see RULE_11
		tri_index = (sum > 6'h0F) ? 4'hF : sum[3:0]; // see RULE_13
	endfunction : tri_index

	// Generated stand-in ROM contents; one word per setting, rf and channel dividers sharing the last, keyed by the 8-bit index
	function automatic logic [31:0] rom_word(input logic [7:0] idx, input logic [3:0] w);
		logic [31:0] seed;
		seed = {idx, idx ^ 8'hA5, 4'(w), idx[3:0] ^ w, idx};
		rom_word = seed ^ (32'(`PPL_SYSCLK_KHZ) << w[1:0]); // see RULE_06
	endfunction : rom_word

	ppl_state_type state_reg, state_next;
	logic [3:0] word_reg, word_next;
	logic [7:0] index_reg, index_next;
	logic started_reg, started_next;
	logic hard_reg, hard_next;
	logic [1:0] strap_sys_reg, strap_sys_next;
	logic [7:0] cal_reg, cal_next;
	logic [7:0] en1_reg, en1_next, en2_reg, en2_next;
	logic [7:0] freq_reg, freq_next, sys_reg, sys_next, loop_reg, loop_next;
	logic [19:0] period_reg, period_next, rdiv_reg, rdiv_next;
	logic [22:0] frac_reg, frac_next, mod_reg, mod_next;
	logic [16:0] nint_reg, nint_next;
	logic [31:0] ftw_reg, ftw_next;
	logic [7:0] n2_reg, n2_next;
	logic [3:0] rf_reg, rf_next;
	logic [9:0] ch_reg, ch_next;
	logic [7:0] rdata_next;
	logic wr_ok;
	logic [31:0] word;

	assign wr_ok = i_reg_wr && (state_reg == PPL_IDLE); // see RULE_17
	assign word = rom_word(index_reg, word_reg);

	always_comb begin
		state_next = state_reg;
		word_next = word_reg;
		index_next = index_reg;
		started_next = 1'b1;
		hard_next = hard_reg;
		strap_sys_next = strap_sys_reg;
		cal_next = cal_reg;
		en1_next = en1_reg;
		en2_next = en2_reg;
		freq_next = freq_reg;
		sys_next = sys_reg;
		loop_next = loop_reg;
		period_next = period_reg;
		rdiv_next = rdiv_reg;
		frac_next = frac_reg;
		mod_next = mod_reg;
		nint_next = nint_reg;
		ftw_next = ftw_reg;
		n2_next = n2_reg;
		rf_next = rf_reg;
		ch_next = ch_reg;
		if (!started_reg) begin
			// Straps caught on the first clock after reset release
			hard_next = i_strap_mode_select_pin; // see RULE_01
			strap_sys_next = 2'(i_irq_pin); // see RULE_16
			if (i_strap_mode_select_pin) begin
				index_next = {tri_index(i_out_sel_pin_high, i_out_sel_pin_mid,
					i_out_sel_pin_low), tri_index(i_input_select_pin_high,
					i_input_select_pin_mid, i_input_select_pin_low)}; // see RULE_03
				word_next = 4'h0;
				state_next = PPL_COPY;
			end
		end
		if (wr_ok) begin
			case (i_reg_addr)
				`PPL_ADDR_APLL_CAL: cal_next = i_reg_wdata;
				`PPL_ADDR_SOFT_EN1: en1_next = i_reg_wdata;
				`PPL_ADDR_SOFT_EN2: en2_next = i_reg_wdata;
				// Select registers stay locked until their section is enabled
				`PPL_ADDR_SOFT_FREQ: if (en1_reg[`PPL_FLD_EN_BIT]) freq_next = i_reg_wdata;
				`PPL_ADDR_SOFT_SYSCLK: if (en1_reg[`PPL_FLD_EN_BIT]) sys_next = i_reg_wdata;
				`PPL_ADDR_SOFT_LOOP: if (en2_reg[`PPL_FLD_EN_BIT]) loop_next = i_reg_wdata;
				`PPL_ADDR_LOAD_CTRL: begin
					if (!hard_reg && i_reg_wdata[`PPL_FLD_START_BIT]) begin
						index_next = {freq_reg[7:4], soft_in_decode(freq_reg[3:0])}; // see RULE_12
						word_next = 4'h0;
						state_next = PPL_COPY;
					end
				end
				default: ;
			endcase
		end
		case (state_reg)
			PPL_IDLE: ;
			PPL_COPY: begin // see RULE_02
				// Same entry feeds every input and every output alike; see RULE_04
				case (word_reg) // see RULE_05
					4'h0: period_next = word[19:0];
					4'h1: rdiv_next = word[19:0];
					4'h2: frac_next = word[22:0];
					4'h3: mod_next = word[22:0];
					4'h4: nint_next = word[16:0];
					4'h5: ftw_next = word;
					4'h6: n2_next = word[7:0];
					default: begin
						rf_next = word[3:0];
						ch_next = word[13:4];
					end
				endcase
				word_next = word_reg + 4'h1;
				if (word_reg == 4'(ROM_WORDS - 1)) begin
					state_next = PPL_CAL_LOW;
				end
			end
			PPL_CAL_LOW: begin
				cal_next = cal_reg & ~8'h01; // see RULE_10
				state_next = PPL_CAL_HIGH;
			end
			PPL_CAL_HIGH: begin
				cal_next = cal_reg | 8'h01; // see RULE_10
				state_next = PPL_IDLE;
			end
			default: state_next = PPL_IDLE;
		endcase
	end

	always_comb begin
		rdata_next = 8'h00;
		if (i_reg_rd) begin
			case (i_reg_addr)
				`PPL_ADDR_APLL_CAL: rdata_next = cal_reg;
				`PPL_ADDR_SOFT_EN1: rdata_next = en1_reg;
				`PPL_ADDR_SOFT_EN2: rdata_next = en2_reg;
				`PPL_ADDR_SOFT_FREQ: rdata_next = en1_reg[0] ? freq_reg : 8'h00;
				`PPL_ADDR_SOFT_SYSCLK: rdata_next = en1_reg[0] ? sys_reg : 8'h00;
				`PPL_ADDR_SOFT_LOOP: rdata_next = en2_reg[0] ? loop_reg : 8'h00;
				`PPL_ADDR_LOAD_STAT: rdata_next = {6'h00, hard_reg, state_reg != PPL_IDLE};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_reg <= PPL_IDLE;
			word_reg <= 4'h0;
			index_reg <= 8'h00;
			started_reg <= 1'b0;
			hard_reg <= 1'b0;
			strap_sys_reg <= 2'b00;
			cal_reg <= `PPL_RST_BYTE;
			en1_reg <= `PPL_RST_BYTE;
			en2_reg <= `PPL_RST_BYTE;
			freq_reg <= `PPL_RST_BYTE;
			sys_reg <= `PPL_RST_BYTE;
			loop_reg <= `PPL_RST_BYTE;
			period_reg <= 20'h0_0000;
			rdiv_reg <= 20'h0_0000;
			frac_reg <= 23'h00_0000;
			mod_reg <= 23'h00_0000;
			nint_reg <= 17'h0_0000;
			ftw_reg <= 32'h0000_0000;
			n2_reg <= 8'h00;
			rf_reg <= 4'h0;
			ch_reg <= 10'h000;
			o_reg_rdata <= 8'h00;
		end else begin
			state_reg <= state_next;
			word_reg <= word_next;
			index_reg <= index_next;
			started_reg <= started_next;
			hard_reg <= hard_next;
			strap_sys_reg <= strap_sys_next;
			cal_reg <= cal_next;
			en1_reg <= en1_next;
			en2_reg <= en2_next;
			freq_reg <= freq_next;
			sys_reg <= sys_next;
			loop_reg <= loop_next;
			period_reg <= period_next;
			rdiv_reg <= rdiv_next;
			frac_reg <= frac_next;
			mod_reg <= mod_next;
			nint_reg <= nint_next;
			ftw_reg <= ftw_next;
			n2_reg <= n2_next;
			rf_reg <= rf_next;
			ch_reg <= ch_next;
			o_reg_rdata <= rdata_next;
		end
	end

	// Rising edge of the calibration bit is a one-cycle start
	logic cal_prev_reg;
	always_ff @(posedge i_clk) begin
		cal_prev_reg <= i_reset ? 1'b0 : cal_reg[`PPL_FLD_CAL_BIT];
	end
	assign o_apll_cal_start = cal_reg[`PPL_FLD_CAL_BIT] && !cal_prev_reg; // see RULE_10

	assign o_ref_period = period_reg;
	assign o_ref_divider = rdiv_reg;
	assign o_dpll_feedback_fraction = frac_reg;
	assign o_dpll_feedback_modulus = mod_reg;
	assign o_dpll_feedback_integer = nint_reg;
	assign o_free_run_word = ftw_reg;
	assign o_output_pll_feedback_divider = n2_reg;
	assign o_rf_divider = rf_reg;
	assign o_channel_divider = ch_reg;
	// Mid level on the interrupt strap maps to preset 1; high to preset 2
	assign o_sysclk_preset = hard_reg ? strap_sys_reg : sys_reg[1:0]; // see RULE_07
	assign o_loop_bw_preset = loop_reg[`PPL_FLD_BW_LSB +: 2]; // see RULE_08
	assign o_high_phase_margin = loop_reg[`PPL_FLD_PM_BIT]; // see RULE_09
	assign o_busy = state_reg != PPL_IDLE; // see RULE_17
	assign o_hard_mode = hard_reg;
	assign o_two_wire_disable = hard_reg; // see RULE_14

	chk_busy_blocks_write: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_17
		(o_busy && i_reg_wr) |=> ($stable(en1_reg) && $stable(en2_reg) && $stable(freq_reg)
		&& $stable(sys_reg) && $stable(loop_reg)))
		else $error("write taken while busy");
	chk_cal_after_copy: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_10
		(state_reg == PPL_COPY && state_next == PPL_CAL_LOW) |-> ##3 o_apll_cal_start)
		else $error("no calibration start after copy");
	chk_copy_length: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_02
		$rose(o_busy) |-> o_busy [*8])
		else $error("copy ended early");
	chk_locked_select: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_15
		(!en1_reg[0] && !o_busy) |=> $stable(freq_reg))
		else $error("select written while locked");
	chk_hard_sysclk: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_16
		(!started_reg && i_strap_mode_select_pin) |=> o_sysclk_preset == 2'($past(i_irq_pin)))
		else $error("hard mode sysclk wrong");
	chk_soft_no_start: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_12
		(started_reg && !hard_reg && !o_busy && !(wr_ok && i_reg_addr == `PPL_ADDR_LOAD_CTRL))
		|=> !o_busy)
		else $error("load started without request");
	chk_rf_loaded: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_05
		(state_reg == PPL_COPY && word_reg == 4'h7) |=> rf_reg == $past(word[3:0]))
		else $error("rf divider not loaded");
	chk_two_wire_off: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_14
		!started_reg |=> o_two_wire_disable == $past(i_strap_mode_select_pin))
		else $error("two wire state wrong");
endmodule : ppl_loader

// >>> dv/ppl_strap_board.sv
// Board model: strap mode pin and tri-level select pins set before reset release
`timescale 1ns/1ps
module ppl_strap_board (
	// Board choices
	input wire logic i_hard,
	input wire logic [4:0] i_in_idx,
	input wire logic [4:0] i_out_idx,
	input wire logic [1:0] i_irq_level,
	// Strap pins
	output logic o_mode_pin,
	output ppl_pkg::ppl_tri_type o_in_high,
	output ppl_pkg::ppl_tri_type o_in_mid,
	output ppl_pkg::ppl_tri_type o_in_low,
	output ppl_pkg::ppl_tri_type o_out_high,
	output ppl_pkg::ppl_tri_type o_out_mid,
	output ppl_pkg::ppl_tri_type o_out_low,
	output ppl_pkg::ppl_tri_type o_irq_pin
);
	import ppl_pkg::*;
	// Levels are static; the bench only changes them while reset is held
	assign o_mode_pin = i_hard;
	assign o_in_high = ppl_tri_type'(2'(i_in_idx / 5'h09));
	assign o_in_mid = ppl_tri_type'(2'((i_in_idx / 5'h03) % 5'h03));
	assign o_in_low = ppl_tri_type'(2'(i_in_idx % 5'h03));
	assign o_out_high = ppl_tri_type'(2'(i_out_idx / 5'h09));
	assign o_out_mid = ppl_tri_type'(2'((i_out_idx / 5'h03) % 5'h03));
	assign o_out_low = ppl_tri_type'(2'(i_out_idx % 5'h03));
	assign o_irq_pin = ppl_tri_type'(i_irq_level);
endmodule : ppl_strap_board

// >>> dv/pin_program_rom_loader_bench.sv
// Self-checking bench for the pin program loader
`timescale 1ns/1ps
`include "ppl_regs.svh"
module pin_program_rom_loader_bench;
	import ppl_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic [15:0] i_reg_addr = 16'h0000;
	logic [7:0] i_reg_wdata = 8'h00;
	logic hard = 1'b0;
	logic [1:0] irq_level = 2'h1;
	logic mode_pin;
	ppl_tri_type in_h, in_m, in_l, out_h, out_m, out_l, irq_pin;
	logic [7:0] o_reg_rdata;
	logic [1:0] o_sysclk_preset;
	logic [1:0] o_loop_bw_preset;
	logic o_high_phase_margin, o_apll_cal_start, o_busy, o_hard_mode, o_two_wire_disable;
	logic [19:0] o_ref_period, o_ref_divider;
	logic [22:0] o_dpll_feedback_fraction, o_dpll_feedback_modulus;
	logic [16:0] o_dpll_feedback_integer;
	logic [31:0] o_free_run_word;
	logic [7:0] o_output_pll_feedback_divider;
	logic [3:0] o_rf_divider;
	logic [9:0] o_channel_divider;
	int n_errors = 0;
	int total_checks = 0;
	int n;
	logic [7:0] rd;

	always #4 i_clk = ~i_clk;

	ppl_strap_board ppl_strap_board_inst (.i_hard(hard), .i_in_idx(5'h05), .i_out_idx(5'h0E),
		.i_irq_level(irq_level), .o_mode_pin(mode_pin), .o_in_high(in_h), .o_in_mid(in_m),
		.o_in_low(in_l), .o_out_high(out_h), .o_out_mid(out_m), .o_out_low(out_l),
		.o_irq_pin(irq_pin));

	ppl_loader ppl_loader_inst (.i_clk(i_clk), .i_reset(i_reset),
		.i_strap_mode_select_pin(mode_pin), .i_input_select_pin_high(in_h),
		.i_input_select_pin_mid(in_m), .i_input_select_pin_low(in_l),
		.i_out_sel_pin_high(out_h), .i_out_sel_pin_mid(out_m), .i_out_sel_pin_low(out_l),
		.i_irq_pin(irq_pin), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_ref_period(o_ref_period),
		.o_ref_divider(o_ref_divider), .o_dpll_feedback_fraction(o_dpll_feedback_fraction),
		.o_dpll_feedback_modulus(o_dpll_feedback_modulus),
		.o_dpll_feedback_integer(o_dpll_feedback_integer), .o_free_run_word(o_free_run_word),
		.o_output_pll_feedback_divider(o_output_pll_feedback_divider),
		.o_rf_divider(o_rf_divider), .o_channel_divider(o_channel_divider),
		.o_sysclk_preset(o_sysclk_preset),
		.o_loop_bw_preset(o_loop_bw_preset), .o_high_phase_margin(o_high_phase_margin),
		.o_apll_cal_start(o_apll_cal_start), .o_busy(o_busy), .o_hard_mode(o_hard_mode),
		.o_two_wire_disable(o_two_wire_disable));

	task automatic give_verdict();
		if (n_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : check

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		#1 rd = o_reg_rdata;
		check(what, exp, rd);
	endtask : rd_chk

	task automatic do_reset(input logic h);
		@(posedge i_clk);
		hard <= h;
		i_reset <= 1'b1;
		repeat (4) @(posedge i_clk);
		i_reset <= 1'b0;
	endtask : do_reset

	// Counts cycles of busy; a stuck loader ends the run
	task automatic busy_len(output int c);
		c = 0;
		while (o_busy === 1'b1 && c < 50) begin
			@(posedge i_clk);
			#1 c++;
		end
		if (c >= 50) begin
			n_errors++;
			give_verdict();
		end
	endtask : busy_len

	initial begin
		do_reset(1'b0);
		rd_chk("status idle", `PPL_ADDR_LOAD_STAT, 8'h00);
		wr(`PPL_ADDR_SOFT_FREQ, 8'h5A);
		rd_chk("freq locked", `PPL_ADDR_SOFT_FREQ, 8'h00);
		wr(`PPL_ADDR_SOFT_EN1, 8'h01);
		wr(`PPL_ADDR_SOFT_FREQ, 8'h5A);
		rd_chk("freq select", `PPL_ADDR_SOFT_FREQ, 8'h5A);
		for (int i = 0; i < 4; i++) begin
			wr(`PPL_ADDR_SOFT_SYSCLK, 8'(i));
			#1 check("sysclk preset", 8'(i), {6'h00, o_sysclk_preset});
		end
		wr(`PPL_ADDR_SOFT_LOOP, 8'h1C);
		rd_chk("loop locked", `PPL_ADDR_SOFT_LOOP, 8'h00);
		wr(`PPL_ADDR_SOFT_EN2, 8'h01);
		for (int i = 0; i < 8; i++) begin
			wr(`PPL_ADDR_SOFT_LOOP, 8'(i << 2));
			#1 check("loop bw", 8'(i % 4), {6'h00, o_loop_bw_preset});
			check("phase margin", 8'(i / 4), {7'h00, o_high_phase_margin});
		end
		rd_chk("unmapped", 16'h0C0F, 8'h00);
		wr(`PPL_ADDR_LOAD_CTRL, 8'h01);
		#1 check("busy start", 8'h01, {7'h00, o_busy});
		busy_len(n);
		check("busy cycles", 8'h0A, 8'(n));
		check("cal pulse", 8'h01, {7'h00, o_apll_cal_start});
		// Stand-in image: N2 word low byte is the entry index, rf word low nibble its input part
		check("soft index", 8'h5B, o_output_pll_feedback_divider);
		check("soft rf", 8'h0B, {4'h0, o_rf_divider});
		check("soft out", 8'h05, {4'h0, o_channel_divider[3:0]});
		check("period loaded", 8'h01, {7'h00, |o_ref_period});
		check("rdiv loaded", 8'h01, {7'h00, |o_ref_divider});
		check("frac loaded", 8'h01, {7'h00, |o_dpll_feedback_fraction});
		check("mod loaded", 8'h01, {7'h00, |o_dpll_feedback_modulus});
		check("nint loaded", 8'h01, {7'h00, |o_dpll_feedback_integer});
		check("ftw loaded", 8'h01, {7'h00, |o_free_run_word});
		wr(`PPL_ADDR_SOFT_FREQ, 8'h39);
		wr(`PPL_ADDR_LOAD_CTRL, 8'h01);
		wr(`PPL_ADDR_SOFT_SYSCLK, 8'h00);
		rd_chk("status busy", `PPL_ADDR_LOAD_STAT, 8'h01);
		busy_len(n);
		check("write dropped", 8'h03, {6'h00, o_sysclk_preset});
		check("swapped code index", 8'h38, o_output_pll_feedback_divider);
		// Hard mode: straps select input 5, output 14, irq pin at mid level
		do_reset(1'b1);
		@(posedge i_clk);
		#1 check("hard busy", 8'h01, {7'h00, o_busy});
		busy_len(n);
		check("hard busy cycles", 8'h0A, 8'(n));
		check("hard index", 8'hE5, o_output_pll_feedback_divider);
		check("hard rf", 8'h05, {4'h0, o_rf_divider});
		check("hard out", 8'h0E, {4'h0, o_channel_divider[3:0]});
		check("hard mode", 8'h03, {6'h00, o_hard_mode, o_two_wire_disable});
		check("hard sysclk", 8'h01, {6'h00, o_sysclk_preset});
		rd_chk("status hard", `PPL_ADDR_LOAD_STAT, 8'h02);
		wr(`PPL_ADDR_LOAD_CTRL, 8'h01);
		#1 check("start ignored", 8'h00, {7'h00, o_busy});
		give_verdict();
	end
endmodule : pin_program_rom_loader_bench
